// >>> logic/card_checker_regs.vh
`ifndef CARD_CHECKER_REGS_VH
`define CARD_CHECKER_REGS_VH

// ====================================================================
// command frame layout, newest bit at position 0
`define FRAME_LAST_BIT 6'd47
`define CRC_COVER_BITS 6'd40
`define CRC7_POLY 7'h09
`define IDX_HI 45
`define IDX_LO 40
`define ARG_HI 39
`define ARG_LO 8
`define CRC_HI 7
`define CRC_LO 1

// ====================================================================
// command indices used outside the class table
`define CMD_RESET 6'h00
`define CMD_INIT 6'h01
`define CMD_STOP 6'h0C
`define CMD_READ_MULTI 6'h12
`define CMD_READ_OCR 6'h3A
`define CMD_CRC_SWITCH 6'h3B

// ====================================================================
// class support: classes with SPI commands (0,2,4,5,6,7,8)
`define SPI_CLASS_MASK 12'h1F5

// ====================================================================
// response status: [15:8] first byte, [7:0] second byte
`define RESP_IDLE_BIT 8
`define RESP_ILLEGAL_BIT 10
`define RESP_CRC_BIT 11
`define RESP_RANGE_BIT 7

// ====================================================================
// operation kinds and timeout budget
`define OP_NONE 2'h0
`define OP_READ 2'h1
`define OP_WRITE 2'h2
`define OP_ERASE 2'h3
`define TIMEOUT_MULT 4'hA

`endif

// >>> logic/spi_cmd_receiver.v
`timescale 1ns/100ps
`include "card_checker_regs.vh"

module spi_cmd_receiver (
    input wire mclk,
    input wire arst_n,
    input wire bitStrobe,
    input wire frameActive,
    input wire bitIn,
    output reg frameDone,
    output reg [5:0] cmdIndex,
    output reg [31:0] cmdArg,
    output reg crcGood
);

    reg [5:0] bitCount;
    reg [46:0] frame;
    reg [6:0] crc;
    wire [47:0] newFrame;
    wire feedback;
    wire [6:0] crcNext;

    // serial crc7 over start, direction, index and argument bits
    assign newFrame = {frame, bitIn};
    assign feedback = crc[6] ^ bitIn;
    assign crcNext = {crc[5:0], 1'b0} ^ (feedback ? `CRC7_POLY : 7'h00);

    // ====================================================================
    // frame assembly; a high bit while waiting is line idle, not a start
    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            bitCount <= 6'h00;
            frame <= 47'h0;
            crc <= 7'h00;
            frameDone <= 1'b0;
            cmdIndex <= 6'h00;
            cmdArg <= 32'h0;
            crcGood <= 1'b0;
        end else if (!frameActive) begin
            // deselect aborts a half-received frame
            bitCount <= 6'h00;
            crc <= 7'h00;
            frameDone <= 1'b0;
        end else begin
            frameDone <= 1'b0;
            if (bitStrobe && !(bitCount == 6'h00 && bitIn)) begin
                frame <= newFrame[46:0];
                if (bitCount < `CRC_COVER_BITS)
                    crc <= crcNext;
                if (bitCount == `FRAME_LAST_BIT) begin
                    bitCount <= 6'h00;
                    crc <= 7'h00;
                    frameDone <= 1'b1;
                    cmdIndex <= newFrame[`IDX_HI:`IDX_LO];
                    cmdArg <= newFrame[`ARG_HI:`ARG_LO];
                    crcGood <= (newFrame[`CRC_HI:`CRC_LO] == crc);
                end else begin
                    bitCount <= bitCount + 6'h01;
                end
            end
        end
    end

endmodule

// >>> logic/op_timeout_budget.v
`timescale 1ns/100ps
`include "card_checker_regs.vh"

module op_timeout_budget (
    input wire mclk,
    input wire arst_n,
    input wire start,
    input wire [1:0] opKind,
    input wire finish,
    input wire [15:0] accessTimeBase,
    input wire [15:0] accessClockCycles,
    input wire [2:0] writeSpeedMultiplier,
    input wire [7:0] eraseSectors,
    output reg expired,
    output reg [39:0] limit
);

    reg [39:0] elapsed;
    reg running;
    wire [39:0] readTime;
    wire [39:0] writeTime;
    wire [39:0] eraseTime;
    reg [39:0] typical;

    // typical times in mclk cycles: read, write and erase budgets
    assign readTime = {24'h0, accessTimeBase} + {24'h0, accessClockCycles};
    assign writeTime = readTime << writeSpeedMultiplier;
    assign eraseTime = writeTime * {32'h0, eraseSectors};

    // ====================================================================
    // pick the typical time of the operation being started
    always @* begin
        case (opKind)
            `OP_READ: typical = readTime;
            `OP_WRITE: typical = writeTime;
            `OP_ERASE: typical = eraseTime;
            default: typical = 40'h0;
        endcase
    end

    // ====================================================================
    // limit is ten typical times; error fires one cycle before it ends
    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            elapsed <= 40'h0;
            running <= 1'b0;
            expired <= 1'b0;
            limit <= 40'h0;
        end else begin
            expired <= 1'b0;
            if (start) begin
                limit <= typical * {36'h0, `TIMEOUT_MULT};
                elapsed <= 40'h0;
                running <= 1'b1;
            end else if (finish) begin
                running <= 1'b0;
            end else if (running) begin
                elapsed <= elapsed + 40'h1;
                // error is reported before the period runs out
                if (elapsed + 40'h2 >= limit) begin
                    expired <= 1'b1;
                    running <= 1'b0;
                end
            end
        end
    end

endmodule

// >>> logic/spi_card_command_checker.v
`timescale 1ns/100ps
`include "card_checker_regs.vh"

module spi_card_command_checker (
    input wire mclk,
    input wire arst_n,
    input wire sclk,
    input wire csN,
    input wire mosi,
    input wire [11:0] cardClassSupport,
    input wire initDone,
    input wire opDone,
    input wire [15:0] accessTimeBase,
    input wire [15:0] accessClockCycles,
    input wire [2:0] writeSpeedMultiplier,
    input wire [7:0] eraseSectors,
    input wire prefetchValid,
    input wire [31:0] prefetchAddr,
    input wire [31:0] lastAddress,
    output reg respValid,
    output reg [15:0] respStatus,
    output reg cmdAccepted,
    output reg [5:0] acceptedIndex,
    output reg [31:0] acceptedArg,
    output reg inIdle,
    output reg multiReadActive,
    output reg opBusy,
    output reg opTimeoutError,
    output reg beyondCapacityFlag,
    output reg crcCheckOn,
    output reg [39:0] timeoutLimit
);

    localparam ST_IDLE = 2'b00;
    localparam ST_READY = 2'b01;
    localparam ST_MULTI = 2'b10;

    // ====================================================================
    // class table: which classes carry each spi command
    function [11:0] classesOf;
        input [5:0] idx;
        begin
            case (idx)
                6'h00, 6'h01, 6'h09, 6'h0A, 6'h0D, 6'h3A, 6'h3B: classesOf = 12'h001;
                6'h0C, 6'h11, 6'h12: classesOf = 12'h004;
                6'h10, 6'h17: classesOf = 12'h014;
                6'h18, 6'h19, 6'h1B: classesOf = 12'h010;
                6'h23, 6'h24, 6'h26: classesOf = 12'h020;
                6'h1C, 6'h1D, 6'h1E: classesOf = 12'h040;
                6'h2A: classesOf = 12'h080;
                6'h37, 6'h38: classesOf = 12'h100;
                default: classesOf = 12'h000;
            endcase
        end
    endfunction

    // ====================================================================
    // which commands start a timed operation, and of which kind
    function [1:0] opKindOf;
        input [5:0] idx;
        begin
            case (idx)
                6'h11, 6'h12: opKindOf = `OP_READ;
                6'h18, 6'h19, 6'h1B, 6'h1C, 6'h1D, 6'h2A: opKindOf = `OP_WRITE;
                6'h26: opKindOf = `OP_ERASE;
                default: opKindOf = `OP_NONE;
            endcase
        end
    endfunction

    // ====================================================================
    // link pins: two flip-flops each before anything looks at them
    wire [2:0] pinIn;
    reg [2:0] pinMeta;
    reg [2:0] pinSync;
    reg sclkLast;
    genvar g;

    assign pinIn = {sclk, csN, mosi};

    generate
        for (g = 0; g < 3; g = g + 1) begin : gSync
            always @(posedge mclk or negedge arst_n) begin
                if (!arst_n) begin
                    pinMeta[g] <= 1'b1;
                    pinSync[g] <= 1'b1;
                end else begin
                    pinMeta[g] <= pinIn[g];
                    pinSync[g] <= pinMeta[g];
                end
            end
        end
    endgenerate

    // rising edge of the host clock found from the synchronised copy
    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n)
            sclkLast <= 1'b1;
        else
            sclkLast <= pinSync[2];
    end

    wire sclkRise;
    wire selected;

    assign sclkRise = pinSync[2] & ~sclkLast;
    assign selected = ~pinSync[1];

    // ====================================================================
    // command frame capture and crc check
    wire frameDone;
    wire [5:0] rxIndex;
    wire [31:0] rxArg;
    wire rxCrcGood;

    spi_cmd_receiver uReceiver (
        .mclk(mclk),
        .arst_n(arst_n),
        .bitStrobe(sclkRise),
        .frameActive(selected),
        .bitIn(pinSync[0]),
        .frameDone(frameDone),
        .cmdIndex(rxIndex),
        .cmdArg(rxArg),
        .crcGood(rxCrcGood)
    );

    // ====================================================================
    // legality of the received command
    reg [1:0] state;
    reg [1:0] next_state;
    reg rangePending;
    wire crcError;
    wire classLegal;
    wire idleLegal;
    wire stopLegal;
    wire illegal;
    wire accept;
    wire [1:0] rxKind;

    assign crcError = crcCheckOn & ~rxCrcGood;
    // one support field serves both modes; classes without spi commands never match
    assign classLegal = |(classesOf(rxIndex) & cardClassSupport & `SPI_CLASS_MASK);
    // reset is honoured in every card state so a confused card can be recovered
    assign idleLegal = (state != ST_IDLE) || (rxIndex == `CMD_INIT) ||
                       (rxIndex == `CMD_READ_OCR) || (rxIndex == `CMD_RESET);
    assign stopLegal = (rxIndex != `CMD_STOP) || (state == ST_MULTI);
    assign illegal = ~classLegal | ~idleLegal | ~stopLegal;
    assign accept = frameDone & ~illegal & ~crcError;
    assign rxKind = opKindOf(rxIndex);

    // ====================================================================
    // card state: idle until initialised, multi read until stopped
    always @* begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (accept && rxIndex == `CMD_INIT && initDone)
                    next_state = ST_READY;
            end
            ST_READY: begin
                if (accept && rxIndex == `CMD_READ_MULTI)
                    next_state = ST_MULTI;
            end
            ST_MULTI: begin
                if (accept && rxIndex == `CMD_STOP)
                    next_state = ST_READY;
            end
            default: next_state = ST_IDLE;
        endcase
        if (accept && rxIndex == `CMD_RESET)
            next_state = ST_IDLE;
    end

    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n)
            state <= ST_IDLE;
        else
            state <= next_state;
    end

    // ====================================================================
    // timeout budget for read, write and erase operations
    wire timerExpired;
    wire [39:0] timerLimit;
    wire opStart;

    assign opStart = accept & (rxKind != `OP_NONE);

    op_timeout_budget uBudget (
        .mclk(mclk),
        .arst_n(arst_n),
        .start(opStart),
        .opKind(rxKind),
        .finish(opDone | (accept && rxIndex == `CMD_RESET)),
        .accessTimeBase(accessTimeBase),
        .accessClockCycles(accessClockCycles),
        .writeSpeedMultiplier(writeSpeedMultiplier),
        .eraseSectors(eraseSectors),
        .expired(timerExpired),
        .limit(timerLimit)
    );

    // busy from a timed command until done, reset or the error fires
    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            opBusy <= 1'b0;
            opTimeoutError <= 1'b0;
            timeoutLimit <= 40'h0;
        end else begin
            opTimeoutError <= timerExpired;
            timeoutLimit <= timerLimit;
            if (opStart)
                opBusy <= 1'b1;
            else if (opDone || timerExpired || (accept && rxIndex == `CMD_RESET))
                opBusy <= 1'b0;
        end
    end

    // ====================================================================
    // prefetch past the end during multi read; a new event beats the clear
    wire prefetchOver;
    wire rangeReport;

    assign prefetchOver = (state == ST_MULTI) && prefetchValid && (prefetchAddr > lastAddress);
    assign rangeReport = accept && rxIndex == `CMD_STOP;

    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n)
            rangePending <= 1'b0;
        else if (prefetchOver)
            rangePending <= 1'b1;
        else if (rangeReport || (accept && rxIndex == `CMD_RESET))
            rangePending <= 1'b0;
    end

    // ====================================================================
    // response status and accepted-command strobe
    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            respValid <= 1'b0;
            respStatus <= 16'h0000;
            cmdAccepted <= 1'b0;
            acceptedIndex <= 6'h00;
            acceptedArg <= 32'h0;
            crcCheckOn <= 1'b0;
        end else begin
            respValid <= frameDone;
            cmdAccepted <= accept;
            if (frameDone) begin
                respStatus <= 16'h0000;
                respStatus[`RESP_IDLE_BIT] <= (next_state == ST_IDLE);
                respStatus[`RESP_ILLEGAL_BIT] <= illegal;
                respStatus[`RESP_CRC_BIT] <= crcError;
                // range error from read-ahead rides on the stop response
                respStatus[`RESP_RANGE_BIT] <= rangeReport & (rangePending | prefetchOver);
            end
            if (accept) begin
                acceptedIndex <= rxIndex;
                acceptedArg <= rxArg;
            end
            // crc checking is optional and switched by its own command
            if (accept && rxIndex == `CMD_CRC_SWITCH)
                crcCheckOn <= rxArg[0];
            else if (accept && rxIndex == `CMD_RESET)
                crcCheckOn <= 1'b0;
        end
    end

    // ====================================================================
    // state mirrors on flip-flops
    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            inIdle <= 1'b1;
            multiReadActive <= 1'b0;
            beyondCapacityFlag <= 1'b0;
        end else begin
            inIdle <= (next_state == ST_IDLE);
            multiReadActive <= (next_state == ST_MULTI);
            beyondCapacityFlag <= rangePending | prefetchOver;
        end
    end

endmodule

// >>> verification/card_checker_asserts.sv
`timescale 1ns/100ps
// ====================================================================
// port checker for the card command checker
module card_checker_asserts (
    input wire mclk,
    input wire arst_n,
    input wire [11:0] cardClassSupport,
    input wire respValid,
    input wire [15:0] respStatus,
    input wire cmdAccepted,
    input wire [5:0] acceptedIndex,
    input wire inIdle,
    input wire multiReadActive,
    input wire opBusy,
    input wire opTimeoutError,
    input wire beyondCapacityFlag,
    input wire [39:0] timeoutLimit
);
    logic [15:0] busyCnt;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!arst_n);

    // cycles spent busy, so the budget can be judged without a long repetition
    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            busyCnt <= 16'h0000;
        end else begin
            busyCnt <= opBusy ? busyCnt + 16'h0001 : 16'h0000;
        end
    end

    // ====================================================================
    // response flags
    a_accept_has_resp: assert property (cmdAccepted |-> respValid && !respStatus[10])
        else $error("accept without a clean response");
    a_crc_blocks_accept: assert property (respValid && respStatus[11] |-> !cmdAccepted)
        else $error("crc error response was also accepted");
    a_resp_one_cycle: assert property (respValid |=> !respValid)
        else $error("response strobe longer than one cycle");
    // ====================================================================
    // legality
    a_defined_only: assert property (cmdAccepted |-> acceptedIndex inside {0, 1, 9, 10, 12, 13, 16, 17,
        18, 23, 24, 25, 27, 28, 29, 30, 35, 36, 38, 42, 55, 56, 58, 59})
        else $error("undefined or unsupported index accepted");
    a_idle_gate: assert property (cmdAccepted && $past(inIdle) |-> acceptedIndex inside {0, 1, 58})
        else $error("command accepted while idle");
    a_write_class: assert property (cmdAccepted && acceptedIndex inside {24, 25, 27} |-> cardClassSupport[4])
        else $error("write accepted without its class");
    a_read_class: assert property (cmdAccepted && acceptedIndex inside {12, 17, 18} |-> cardClassSupport[2])
        else $error("read accepted without its class");
    a_stop_in_read: assert property (cmdAccepted && acceptedIndex == 6'h0C |-> $past(multiReadActive))
        else $error("stop accepted outside multi read");
    // ====================================================================
    // budget and prefetch range
    a_budget_bound: assert property (opBusy && busyCnt > 16'h0002 |-> busyCnt < timeoutLimit)
        else $error("busy past the timeout limit");
    a_stop_clears: assert property (cmdAccepted && acceptedIndex == 6'h0C |=> !beyondCapacityFlag)
        else $error("range flag survived the stop");
    a_range_in_read: assert property ($rose(beyondCapacityFlag) |-> $past(multiReadActive))
        else $error("range flag outside multi read");

    c_accept: cover property (cmdAccepted);
    c_illegal: cover property (respValid && respStatus[10]);
    c_expire: cover property (opTimeoutError);
    c_range: cover property ($rose(beyondCapacityFlag));
endmodule

bind spi_card_command_checker card_checker_asserts i_card_checker_asserts (.mclk, .arst_n,
    .cardClassSupport, .respValid, .respStatus, .cmdAccepted, .acceptedIndex, .inIdle,
    .multiReadActive, .opBusy, .opTimeoutError, .beyondCapacityFlag, .timeoutLimit);

// >>> verification/spi_host_model.sv
`timescale 1ns/100ps
// ====================================================================
// host side of the link: clock parked low outside frames, data pulled up
module spi_host_model (
    output logic sclk,
    output logic csN,
    output logic mosi
);
    initial begin
        sclk = 1'b0;
        csN = 1'b1;
        mosi = 1'b1;
    end

    // one 48-bit frame, msb first; bad flips the crc lsb on purpose
    task automatic send(input logic [5:0] idx, input logic [31:0] arg, input logic bad);
        int i;
        logic [6:0] crc;
        logic [39:0] head;
        logic [47:0] frame;
        head = {2'b01, idx, arg};
        crc = 7'h00;
        for (i = 39; i >= 0; i--) begin
            crc = {crc[5:0], 1'b0} ^ ((head[i] ^ crc[6]) ? 7'h09 : 7'h00);
        end
        frame = {head, crc ^ {6'h00, bad}, 1'b1};
        csN = 1'b0;
        for (i = 47; i >= 0; i--) begin
            mosi = frame[i];
            #80 sclk = 1'b1;
            #80 sclk = 1'b0;
        end
        csN = 1'b1;
        mosi = 1'b1;
        #80; // deselect must reach the card before the next frame
    endtask
endmodule

// >>> verification/spi_card_command_checker_test.sv
`timescale 1ns/100ps
// ====================================================================
// bench for the card command checker
module spi_card_command_checker_test;
    logic mclk, arst_n, sclk, csN, mosi, initDone, opDone, prefetchValid;
    logic [11:0] cardClassSupport;
    logic [15:0] accessTimeBase, accessClockCycles;
    logic [2:0] writeSpeedMultiplier;
    logic [7:0] eraseSectors;
    logic [31:0] prefetchAddr, lastAddress, acceptedArg;
    logic respValid, cmdAccepted, inIdle, multiReadActive, opBusy, opTimeoutError, beyondCapacityFlag, crcCheckOn;
    logic [15:0] respStatus;
    logic [5:0] acceptedIndex;
    logic [39:0] timeoutLimit;
    int fails = 0;
    int checked = 0;
    int i, m;
    logic [5:0] badIdx [16] = '{2, 3, 5, 6, 7, 8, 11, 14, 15, 19, 20, 21, 26, 39, 40, 63};
    logic [5:0] goodIdx [11] = '{9, 10, 13, 16, 23, 30, 35, 36, 55, 56, 58};
    logic [5:0] gateIdx [5] = '{16, 17, 24, 38, 42};
    logic [11:0] gateMask [2] = '{12'h141, 12'hE0B};

    spi_host_model i_spi_host_model (.sclk(sclk), .csN(csN), .mosi(mosi));

    spi_card_command_checker i_spi_card_command_checker (.mclk(mclk), .arst_n(arst_n), .sclk(sclk), .csN(csN),
        .mosi(mosi), .cardClassSupport(cardClassSupport), .initDone(initDone), .opDone(opDone),
        .accessTimeBase(accessTimeBase), .accessClockCycles(accessClockCycles),
        .writeSpeedMultiplier(writeSpeedMultiplier), .eraseSectors(eraseSectors),
        .prefetchValid(prefetchValid), .prefetchAddr(prefetchAddr), .lastAddress(lastAddress),
        .respValid(respValid), .respStatus(respStatus), .cmdAccepted(cmdAccepted),
        .acceptedIndex(acceptedIndex), .acceptedArg(acceptedArg), .inIdle(inIdle),
        .multiReadActive(multiReadActive), .opBusy(opBusy), .opTimeoutError(opTimeoutError),
        .beyondCapacityFlag(beyondCapacityFlag), .crcCheckOn(crcCheckOn), .timeoutLimit(timeoutLimit));

    // 100 MHz system clock
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic complete_run();
        if (fails == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // send one frame and catch {crc error, illegal, accepted} in the strobe cycle
    task automatic cmd(input logic [5:0] idx, input logic [31:0] arg, input logic bad, input logic [2:0] exp);
        int n;
        logic [2:0] got;
        got = 3'bxxx;
        fork
            i_spi_host_model.send(idx, arg, bad);
            begin
                n = 0;
                while (respValid !== 1'b1 && n < 2000) begin
                    @(negedge mclk);
                    n++;
                end
                // a silent card must not pass on stale status
                got = (n < 2000) ? {respStatus[11:10], cmdAccepted} : 3'bxxx;
            end
        join
        chk(got, exp);
    endtask

    // budget figure, then the early error must beat the limit
    task automatic expire(input logic [39:0] lim);
        int n;
        chk(timeoutLimit, lim);
        n = 0;
        while (opTimeoutError !== 1'b1 && n < 1000) begin
            @(negedge mclk);
            n++;
        end
        chk(n < lim, 1);
    endtask

    task automatic pulse(input logic isPrefetch, input logic [31:0] addr);
        @(negedge mclk);
        prefetchValid = isPrefetch;
        opDone = ~isPrefetch;
        prefetchAddr = addr;
        @(negedge mclk);
        prefetchValid = 1'b0;
        opDone = 1'b0;
        @(negedge mclk);
    endtask

    // hang guard, well beyond the ~52 frames of the run
    initial begin
        #1000000;
        fails++;
        complete_run();
    end

    // ====================================================================
    // main sequence
    initial begin
        arst_n = 1'b0;
        cardClassSupport = 12'h1F5;
        initDone = 1'b1;
        opDone = 1'b0;
        accessTimeBase = 16'h0002;
        accessClockCycles = 16'h0003;
        writeSpeedMultiplier = 3'h1;
        eraseSectors = 8'h02;
        prefetchValid = 1'b0;
        prefetchAddr = 32'h0000_0000;
        lastAddress = 32'h0000_0FFF;
        repeat (4) @(negedge mclk);
        arst_n = 1'b1;
        repeat (3) @(negedge mclk);
        chk(inIdle, 1);
        chk(respStatus, 16'h0000);
        cmd(6'd17, 32'h0, 1'b0, 3'b010);
        chk(respStatus[8], 1);
        cmd(6'd58, 32'h0, 1'b0, 3'b001);
        cmd(6'd1, 32'h0, 1'b0, 3'b001);
        chk({inIdle, respStatus[8]}, 0);
        cmd(6'd59, 32'h1, 1'b0, 3'b001);
        chk(crcCheckOn, 1);
        cmd(6'd13, 32'h0, 1'b1, 3'b100);
        for (i = 0; i < 16; i++) cmd(badIdx[i], 32'h0, 1'b0, 3'b010);
        for (i = 0; i < 11; i++) cmd(goodIdx[i], 32'h0, 1'b0, 3'b001);
        for (m = 0; m < 2; m++) begin
            cardClassSupport = gateMask[m];
            for (i = 0; i < 5; i++) cmd(gateIdx[i], 32'h0, 1'b0, 3'b010);
        end
        cardClassSupport = 12'h1F5;
        cmd(6'd12, 32'h0, 1'b0, 3'b010);
        cmd(6'd17, 32'h10, 1'b0, 3'b001);
        expire(40'd50);
        cmd(6'd24, 32'h10, 1'b0, 3'b001);
        expire(40'd100);
        cmd(6'd28, 32'h10, 1'b0, 3'b001);
        expire(40'd100);
        cmd(6'd38, 32'h0, 1'b0, 3'b001);
        expire(40'd200);
        cmd(6'd25, 32'h10, 1'b0, 3'b001);
        chk(opBusy, 1);
        pulse(1'b0, 32'h0);
        chk(opBusy, 0);
        cmd(6'd18, 32'hFF0, 1'b0, 3'b001);
        chk(multiReadActive, 1);
        chk({acceptedIndex, acceptedArg}, {6'd18, 32'h0000_0FF0});
        pulse(1'b0, 32'h0);
        pulse(1'b1, 32'h0000_0FFF);
        chk(beyondCapacityFlag, 0);
        pulse(1'b1, 32'h0000_1000);
        chk(beyondCapacityFlag, 1);
        cmd(6'd12, 32'h0, 1'b0, 3'b001);
        chk(respStatus[7], 1);
        chk({beyondCapacityFlag, multiReadActive}, 0);
        cmd(6'd0, 32'h0, 1'b0, 3'b001);
        chk({inIdle, crcCheckOn}, 2'b10);
        // init not finished: the card stays idle after an accepted init command
        initDone = 1'b0;
        cmd(6'd1, 32'h0, 1'b0, 3'b001);
        chk({inIdle, respStatus[8]}, 2'b11);
        complete_run();
    end
endmodule
